// ===== rtl/ecc_pkg.sv
// Constants, carriers and states for the four-byte group error correction
// Contract
// - Correction invisible to bus traffic and acknowledges
// - Codeword is aligned four-byte group
// - Single wrong bit in group corrected on read
// - Byte write rewrites whole group, fresh check
// - Each write command: one cycle, group once
// - Programming starts only at stop condition
// - Page writes wrap low seven address bits
// - No acknowledge while programming runs
package ecc_pkg;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 32;
    localparam int CHK_W = 6;
    localparam int CW_W = DATA_W + CHK_W;
    localparam int ADDR_W = 15;
    localparam int SEL_W = 2;
    localparam int GRP_W = ADDR_W - SEL_W;
    localparam int OFS_W = 7;
    localparam int PAGE_W = ADDR_W - OFS_W;
    localparam int PAGE_BYTES = 128;
    localparam int GRP_BYTES = 4;
    localparam int GIDX_W = OFS_W - SEL_W;
    localparam logic [GIDX_W-1:0] GIDX_LAST = 5'h1f;
    localparam int CNT_W = 24;
    localparam int T_WR_MS = 5;
    localparam int CLK_KHZ = 100000;
    localparam int PROG_CYCLES_DEF = T_WR_MS * CLK_KHZ;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } byte_wr_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } rd_req_t;

    typedef struct packed {
        logic valid;
        logic [BYTE_W-1:0] data;
    } byte_rd_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [GRP_W-1:0] grp;
        logic [CW_W-1:0] wdata;
    } array_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_WAIT = 3'h1,
        ST_RD_DATA = 3'h2,
        ST_PG_SCAN = 3'h3,
        ST_PG_WAIT = 3'h4,
        ST_PG_MERGE = 3'h5,
        ST_PG_TIME = 3'h6
    } state_t;
endpackage : ecc_pkg

// ===== rtl/group_ecc.sv
// Group error correction layer between serial front end and array
`timescale 1ns/1ps
module group_ecc #(
    parameter int unsigned PROG_CYCLES = ecc_pkg::PROG_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire ecc_pkg::byte_wr_t wr_in,
    input wire logic stop_in,
    input wire ecc_pkg::rd_req_t rd_in,
    input wire logic [ecc_pkg::CW_W-1:0] arr_rdata_in,
    output ecc_pkg::byte_rd_t rd_out,
    output logic busy_out,
    output ecc_pkg::array_req_t arr_out
);
    import ecc_pkg::*;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Check bits: XOR of codeword positions of set data bits
    function automatic logic [CHK_W-1:0] hamming_chk(
        input logic [DATA_W-1:0] d);
        logic [CHK_W-1:0] c;
        int j;
        c = '0;
        j = 0;
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[j])
                    c = c ^ CHK_W'(p);
                j++;
            end
        end
        return c;
    endfunction : hamming_chk

    // Flips the data bit that the syndrome points at
    function automatic logic [DATA_W-1:0] fix_word(
        input logic [DATA_W-1:0] d, input logic [CHK_W-1:0] chk);
        logic [CHK_W-1:0] s;
        logic [DATA_W-1:0] r;
        int j;
        s = chk ^ hamming_chk(d);
        r = d;
        j = 0;
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (s == CHK_W'(p))
                    r[j] = ~r[j];
                j++;
            end
        end
        return r;
    endfunction : fix_word

    state_t state_r, state_nxt;
    logic [BYTE_W-1:0] buf_r [PAGE_BYTES];
    logic [BYTE_W-1:0] buf_nxt [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] vld_r, vld_nxt;
    logic [OFS_W-1:0] ofs_r, ofs_nxt;
    logic [PAGE_W-1:0] page_r, page_nxt;
    logic [GIDX_W-1:0] gidx_r, gidx_nxt;
    logic [SEL_W-1:0] sel_r, sel_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    byte_rd_t rd_r, rd_nxt;
    logic busy_r, busy_nxt;
    array_req_t arr_r, arr_nxt;
    logic [DATA_W-1:0] corr_w;

    assign corr_w = fix_word(arr_rdata_in[DATA_W-1:0],
                             arr_rdata_in[CW_W-1:DATA_W]);

    always_comb begin
        logic [OFS_W-1:0] o;
        logic [DATA_W-1:0] m;
        o = '0;
        m = corr_w;
        state_nxt = state_r;
        buf_nxt = buf_r;
        vld_nxt = vld_r;
        ofs_nxt = ofs_r;
        page_nxt = page_r;
        gidx_nxt = gidx_r;
        sel_nxt = sel_r;
        cnt_nxt = cnt_r;
        rd_nxt = '0;
        busy_nxt = busy_r;
        arr_nxt = arr_r;
        arr_nxt.rd = 1'b0;
        arr_nxt.wr = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (wr_in.valid) begin
                    if (vld_r == '0) begin
                        o = wr_in.addr[OFS_W-1:0];
                        page_nxt = wr_in.addr[ADDR_W-1:OFS_W];
                    end else begin
                        o = ofs_r;
                    end
                    buf_nxt[o] = wr_in.data;
                    vld_nxt[o] = 1'b1;
                    ofs_nxt = o + 1'b1;
                end else if (stop_in && vld_r != '0) begin
                    state_nxt = ST_PG_SCAN;
                    gidx_nxt = '0;
                    busy_nxt = 1'b1;
                end else if (rd_in.valid) begin
                    arr_nxt.rd = 1'b1;
                    arr_nxt.grp = rd_in.addr[ADDR_W-1:SEL_W];
                    sel_nxt = rd_in.addr[SEL_W-1:0];
                    state_nxt = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: state_nxt = ST_RD_DATA;
            ST_RD_DATA: begin
                rd_nxt.valid = 1'b1;
                rd_nxt.data = corr_w[sel_r*BYTE_W +: BYTE_W];
                state_nxt = ST_IDLE;
            end
            ST_PG_SCAN: begin
                if (vld_r[gidx_r*GRP_BYTES +: GRP_BYTES] != '0) begin
                    arr_nxt.rd = 1'b1;
                    arr_nxt.grp = {page_r, gidx_r};
                    state_nxt = ST_PG_WAIT;
                end else if (gidx_r == GIDX_LAST) begin
                    state_nxt = ST_PG_TIME;
                    cnt_nxt = '0;
                end else begin
                    gidx_nxt = gidx_r + 1'b1;
                end
            end
            ST_PG_WAIT: state_nxt = ST_PG_MERGE;
            ST_PG_MERGE: begin
                for (int b = 0; b < GRP_BYTES; b++) begin
                    if (vld_r[{gidx_r, SEL_W'(b)}])
                        m[b*BYTE_W +: BYTE_W] =
                            buf_r[{gidx_r, SEL_W'(b)}];
                end
                arr_nxt.wr = 1'b1;
                arr_nxt.wdata = {hamming_chk(m), m};
                if (gidx_r == GIDX_LAST) begin
                    state_nxt = ST_PG_TIME;
                    cnt_nxt = '0;
                end else begin
                    gidx_nxt = gidx_r + 1'b1;
                    state_nxt = ST_PG_SCAN;
                end
            end
            ST_PG_TIME: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r >= CNT_W'(PROG_CYCLES - 1)) begin
                    state_nxt = ST_IDLE;
                    busy_nxt = 1'b0;
                    vld_nxt = '0;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r <= ST_IDLE;
            vld_r <= '0;
            ofs_r <= '0;
            page_r <= '0;
            gidx_r <= '0;
            sel_r <= '0;
            cnt_r <= '0;
            rd_r <= '0;
            busy_r <= 1'b0;
            arr_r <= '0;
        end else begin
            state_r <= state_nxt;
            vld_r <= vld_nxt;
            ofs_r <= ofs_nxt;
            page_r <= page_nxt;
            gidx_r <= gidx_nxt;
            sel_r <= sel_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            busy_r <= busy_nxt;
            arr_r <= arr_nxt;
        end
        buf_r <= buf_nxt;
    end

    assign rd_out = rd_r;
    assign busy_out = busy_r;
    assign arr_out = arr_r;

    // Checks
    logic [CHK_W-1:0] syn_w;
    assign syn_w = arr_rdata_in[CW_W-1:DATA_W]
                   ^ hamming_chk(arr_rdata_in[DATA_W-1:0]);

    read_latency_a: assert property (
        state_r == ST_IDLE && rd_in.valid && !wr_in.valid && !stop_in
        |=> !rd_out.valid ##1 !rd_out.valid ##1 rd_out.valid)
        else $error("read answer not three cycles after request");
    group_addr_a: assert property (
        state_r == ST_IDLE && rd_in.valid && !wr_in.valid && !stop_in
        |=> arr_out.rd && arr_out.grp == $past(rd_in.addr[ADDR_W-1:SEL_W]))
        else $error("array group address wrong");
    clean_read_a: assert property (
        state_r == ST_RD_DATA && syn_w == '0
        |=> rd_out.data == $past(arr_rdata_in[sel_r*BYTE_W +: BYTE_W]))
        else $error("clean word altered on read");
    write_check_a: assert property (
        arr_out.wr |-> arr_out.wdata[CW_W-1:DATA_W]
                       == hamming_chk(arr_out.wdata[DATA_W-1:0]))
        else $error("written check bits wrong");
    single_write_a: assert property (
        arr_out.wr |=> !arr_out.wr ##1 !arr_out.wr)
        else $error("group written twice in a row");
    stop_start_a: assert property (
        state_r == ST_IDLE && stop_in && !wr_in.valid && vld_r != '0
        |=> busy_out && state_r == ST_PG_SCAN)
        else $error("program cycle not started at stop");
    page_wrap_a: assert property (
        state_r == ST_IDLE && wr_in.valid && vld_r != '0
        |=> ofs_r == OFS_W'($past(ofs_r) + 1'b1)
            && page_r == $past(page_r))
        else $error("page offset not wrapped in page");
    busy_quiet_a: assert property (
        busy_out |-> !rd_out.valid && state_r != ST_RD_WAIT)
        else $error("read served while programming");
    merge_order_a: assert property (
        arr_out.rd && busy_out |-> ##2 arr_out.wr)
        else $error("partial group not merged after read");

    read_cov_c: cover property (rd_out.valid);
    prog_cov_c: cover property (busy_out ##1 arr_out.wr);
    done_cov_c: cover property ($fell(busy_out));
    fix_cov_c: cover property (state_r == ST_RD_DATA && syn_w != '0);
endmodule : group_ecc

// ===== tb/array_model.sv
// Array model: one-cycle read latency, commanded bit flips
`timescale 1ns/1ps
module array_model (
    input wire logic clk_in,
    input wire ecc_pkg::array_req_t arr_in,
    input wire logic [ecc_pkg::CW_W-1:0] flip_in,
    output logic [ecc_pkg::CW_W-1:0] rdata_out
);
    import ecc_pkg::*;
    logic [CW_W-1:0] mem [2**GRP_W] = '{default: '0};
    logic [CW_W-1:0] last_r = '0;
    logic rd_r = 1'b0;
    always @(posedge clk_in) begin
        rd_r <= arr_in.rd;
        if (arr_in.rd) last_r <= mem[arr_in.grp] ^ flip_in;
        if (arr_in.wr) mem[arr_in.grp] <= arr_in.wdata;
    end
    // Outside the data cycle the lines show the inverse of the last word
    assign rdata_out = rd_r ? last_r : ~last_r;
endmodule : array_model

// ===== tb/tb_top.sv
// Self-checking bench for the group error correction layer
`timescale 1ns/1ps
module tb_top;
    import ecc_pkg::*;
    logic clk_in, reset_in, stop_in, busy_out;
    byte_wr_t wr_in;
    rd_req_t rd_in;
    byte_rd_t rd_out;
    array_req_t arr_out;
    logic [CW_W-1:0] arr_rdata, flip;
    int error_cnt = 0, comparisons = 0, cyc = 0, wr_cnt = 0;
    logic [GRP_W-1:0] last_grp;

    group_ecc #(.PROG_CYCLES(8)) group_ecc_i (.clk_in(clk_in),
        .reset_in(reset_in), .wr_in(wr_in), .stop_in(stop_in),
        .rd_in(rd_in), .arr_rdata_in(arr_rdata), .rd_out(rd_out),
        .busy_out(busy_out), .arr_out(arr_out));
    array_model array_model_i (.clk_in(clk_in), .arr_in(arr_out),
        .flip_in(flip), .rdata_out(arr_rdata));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (arr_out.wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_grp <= arr_out.grp;
        end
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic check(input logic [CW_W-1:0] seen,
                         input logic [CW_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("Errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic wr_burst(input logic [ADDR_W-1:0] a, input int n,
                            input logic [BYTE_W-1:0] d0);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_in);
            wr_in <= '{1'b1, a, d0 + BYTE_W'(i)};
        end
        @(negedge clk_in);
        wr_in <= '0;
    endtask : wr_burst

    task automatic prog(input int n, input logic [GRP_W-1:0] g,
                        input bit inj);
        int w0;
        int k;
        w0 = wr_cnt;
        @(negedge clk_in);
        stop_in <= 1'b1;
        @(negedge clk_in);
        stop_in <= 1'b0;
        check(CW_W'(busy_out), CW_W'(n > 0));
        if (inj) begin
            wr_in <= '{1'b1, ADDR_W'(16), 8'h99};
            @(negedge clk_in);
            wr_in <= '0;
        end
        k = 0;
        while (busy_out === 1'b1 && k < 400) begin
            @(negedge clk_in);
            k++;
        end
        check(CW_W'(busy_out), CW_W'(0));
        check(CW_W'(wr_cnt - w0), CW_W'(n));
        if (n > 0) check(CW_W'(last_grp), CW_W'(g));
    endtask : prog

    task automatic rd(input logic [ADDR_W-1:0] a,
                      input logic [BYTE_W-1:0] exp);
        int k;
        @(negedge clk_in);
        rd_in <= '{1'b1, a};
        @(negedge clk_in);
        rd_in <= '0;
        k = 1;
        while (rd_out.valid !== 1'b1 && k < 8) begin
            @(negedge clk_in);
            k++;
        end
        check(CW_W'(k), CW_W'(3));
        check(CW_W'(rd_out.data), CW_W'(exp));
    endtask : rd

    // Single byte write rewrites its group, neighbours kept
    task automatic t_byte();
        wr_burst(15'h0005, 1, 8'h5a);
        prog(1, 13'h0001, 1'b0);
        rd(15'h0005, 8'h5a);
        rd(15'h0004, 8'h00);
        rd(15'h0007, 8'h00);
    endtask : t_byte

    // Every single flipped bit of the codeword is corrected
    task automatic t_flip();
        for (int i = 0; i < CW_W; i++) begin
            flip = CW_W'(1) << i;
            rd(15'h0005, 8'h5a);
        end
        flip = '0;
    endtask : t_flip

    // Page wrap over two partial groups, flipped bit merged back clean
    task automatic t_page();
        wr_burst(15'h007e, 4, 8'h30);
        flip = CW_W'(1) << 16;
        prog(2, 13'h001f, 1'b0);
        flip = '0;
        rd(15'h0000, 8'h32);
        rd(15'h0001, 8'h33);
        rd(15'h0002, 8'h00);
        rd(15'h007f, 8'h31);
        rd(15'h007c, 8'h00);
    endtask : t_page

    // Write while programming is refused, empty stop starts nothing
    task automatic t_busy();
        wr_burst(15'h0010, 1, 8'h11);
        prog(1, 13'h0004, 1'b1);
        prog(0, 13'h0000, 1'b0);
        rd(15'h0010, 8'h11);
    endtask : t_busy

    initial begin
        reset_in = 1'b1;
        stop_in = 1'b0;
        wr_in = '0;
        rd_in = '0;
        flip = '0;
        repeat (20) @(negedge clk_in);
        reset_in <= 1'b0;
        t_byte();
        t_flip();
        t_page();
        t_busy();
        close_out();
    end
endmodule : tb_top
